// ===== rtl/ubg_consts.svh
// register offsets, field positions and timing counts of the baud generator block
`ifndef UBG_CONSTS_SVH
`define UBG_CONSTS_SVH
`define UBG_ADDR_W            4
`define UBG_OFS_DATA          4'h0
`define UBG_OFS_DIVISOR       4'h1
`define UBG_OFS_CTRL2         4'h2
`define UBG_OFS_STATUS        4'h3
`define UBG_OFS_RXPUSH        4'h4
`define UBG_CTRL2_HS_BIT      5
`define UBG_CTRL2_RESET       8'h00
`define UBG_DIVISOR_RESET     8'h00
`define UBG_DATA_RESET        8'h00
`define UBG_PRESCALE_LOW      7'h40
`define UBG_PRESCALE_HIGH     7'h10
`define UBG_FIFO_DEPTH        16
`define UBG_FIFO_WIDTH        8
`endif

// ===== rtl/ubg_pkg.sv
// types shared by the baud generator and data buffer block
package ubg_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ubg_bus_req_t;
    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } ubg_byte_t;
endpackage

// ===== rtl/ubg_fifo.sv
// intentionally empty: the fifo module is declared in the core file beside its user

// ===== rtl/ubg_core.sv
// baud rate generator with shared transmit/receive data buffer and tx fifo
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ubg_consts.svh"
// Function
// - one 8-bit read/write data buffer, bits 7 down to 0, carries the byte sent and the byte received.
// - with the speed select low the bit rate is the system clock over 64 times divisor plus one.
// - with the speed select high the bit rate is the system clock over 16 times divisor plus one.
// - bit timing comes from a dedicated free-running 8-bit timer set by divisor and speed select.
// - the speed select bit chooses the high-speed or low-speed prescale mode.
// - any divisor from 0 to 255 is accepted and used directly as N.
// - transmitter and receiver share one generated bit rate and one frame format.
// - the speed select is bit 5 of the second control register, read/write, cleared at reset.
module ubg_core #(
    parameter int FIFO_DEPTH = `UBG_FIFO_DEPTH
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire ubg_pkg::ubg_bus_req_t bus_req,
    output logic [7:0]                rdata,
    input  wire logic [7:0]           rx_byte,
    input  wire logic                 rx_byte_valid,
    output logic [7:0]                tx_byte,
    output logic                      tx_byte_valid,
    input  wire logic                 tx_byte_ready,
    output logic                      bit_tick,
    output logic                      wr_refused
);
    import ubg_pkg::*;

    logic [7:0] divisor_reg;
    logic [7:0] ctrl2_reg;
    logic [7:0] rx_data_reg;
    logic [7:0] rdata_reg;
    logic [6:0] pre_cnt_reg;
    logic [7:0] baud_cnt_reg;
    logic       tick_reg;
    logic [7:0] tx_byte_reg;
    logic       tx_valid_reg;
    logic       refused_reg;

    wire        wr_data    = bus_req.wr && (bus_req.addr == `UBG_OFS_DATA);
    wire        wr_div     = bus_req.wr && (bus_req.addr == `UBG_OFS_DIVISOR);
    wire        wr_ctrl2   = bus_req.wr && (bus_req.addr == `UBG_OFS_CTRL2);
    wire        wr_rxpush  = bus_req.wr && (bus_req.addr == `UBG_OFS_RXPUSH);
    wire        cfg_wr     = wr_div || wr_ctrl2;
    wire        hs_wdata   = bus_req.wdata[`UBG_CTRL2_HS_BIT];
    wire        high_speed = ctrl2_reg[`UBG_CTRL2_HS_BIT];
    // prescale terminal count picks 16 or 64 system clocks per timer step
    wire  [6:0] pre_last   = high_speed ? (`UBG_PRESCALE_HIGH - 7'h01)
                                        : (`UBG_PRESCALE_LOW - 7'h01);
    wire        pre_wrap   = (pre_cnt_reg >= pre_last);
    wire        baud_wrap  = pre_wrap && (baud_cnt_reg >= divisor_reg);

    // fifo between the data buffer and the transmit shifter
    logic       fifo_in_ready;
    logic [7:0] fifo_out_data;
    logic       fifo_out_valid;
    wire        fifo_pop   = fifo_out_valid && (!tx_valid_reg || tx_byte_ready);
    wire        push_ok    = wr_data && fifo_in_ready;
    wire  [1:0] status     = {fifo_out_valid || tx_valid_reg, fifo_in_ready};

    ubg_fifo #(
        .WIDTH (`UBG_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_data   (bus_req.wdata),
        .in_valid  (wr_data),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (!tx_valid_reg || tx_byte_ready)
    );

    logic [7:0] rd_mux;
    always_comb begin
        unique case (bus_req.addr)
            `UBG_OFS_DATA:    rd_mux = rx_data_reg;
            `UBG_OFS_DIVISOR: rd_mux = divisor_reg;
            `UBG_OFS_CTRL2:   rd_mux = ctrl2_reg;
            `UBG_OFS_STATUS:  rd_mux = {6'h00, status};
            default:          rd_mux = 8'h00;
        endcase
    end

    // control registers
    always_ff @(posedge clk) begin
        if (srst) begin
            divisor_reg <= `UBG_DIVISOR_RESET;
            ctrl2_reg   <= `UBG_CTRL2_RESET;
        end else begin
            if (wr_div) begin
                divisor_reg <= bus_req.wdata;
            end
            if (wr_ctrl2) begin
                ctrl2_reg <= bus_req.wdata;
            end
        end
    end

    // received byte lands in the buffer; a software test write may load it too
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_data_reg <= `UBG_DATA_RESET;
        end else if (rx_byte_valid) begin
            rx_data_reg <= rx_byte;
        end else if (wr_rxpush) begin
            rx_data_reg <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= bus_req.rd ? rd_mux : 8'h00;
        end
    end

    // free-running timer: prescaler then 8-bit divisor counter
    always_ff @(posedge clk) begin
        if (srst) begin
            pre_cnt_reg  <= 7'h00;
            baud_cnt_reg <= 8'h00;
            tick_reg     <= 1'b0;
        end else begin
            pre_cnt_reg <= pre_wrap ? 7'h00 : pre_cnt_reg + 7'h01;
            if (baud_wrap) begin
                baud_cnt_reg <= 8'h00;
            end else if (pre_wrap) begin
                baud_cnt_reg <= baud_cnt_reg + 8'h01;
            end
            tick_reg <= baud_wrap;
        end
    end

    // transmit side output stage, stalls the fifo under back-pressure
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_byte_reg  <= 8'h00;
            tx_valid_reg <= 1'b0;
            refused_reg  <= 1'b0;
        end else begin
            if (fifo_pop) begin
                tx_byte_reg  <= fifo_out_data;
                tx_valid_reg <= 1'b1;
            end else if (tx_byte_ready) begin
                tx_valid_reg <= 1'b0;
            end
            // a write against a full fifo is dropped and flagged for one cycle
            refused_reg <= wr_data && !push_ok;
        end
    end

    assign rdata         = rdata_reg;
    assign tx_byte       = tx_byte_reg;
    assign tx_byte_valid = tx_valid_reg;
    assign bit_tick      = tick_reg;
    assign wr_refused    = refused_reg;

    // period checker: cycles between ticks must equal prescale times divisor plus one
    logic [16:0] gap_cnt_reg;
    logic        seen_tick_reg;
    logic [7:0]  div_hold_reg;
    logic        hs_hold_reg;
    logic        cfg_stable_reg;
    wire  [16:0] expect_gap = (hs_hold_reg ? 17'h00010 : 17'h00040) * (17'(div_hold_reg) + 17'h00001);
    always_ff @(posedge clk) begin
        if (srst) begin
            gap_cnt_reg    <= 17'h00000;
            seen_tick_reg  <= 1'b0;
            div_hold_reg   <= 8'h00;
            hs_hold_reg    <= 1'b0;
            cfg_stable_reg <= 1'b0;
        end else begin
            gap_cnt_reg <= tick_reg ? 17'h00001 : gap_cnt_reg + 17'h00001;
            if (tick_reg) begin
                seen_tick_reg  <= 1'b1;
                div_hold_reg   <= divisor_reg;
                hs_hold_reg    <= high_speed;
                // a write in the tick cycle already shapes the coming period
                cfg_stable_reg <= !cfg_wr;
            end else if (wr_div || wr_ctrl2) begin
                cfg_stable_reg <= 1'b0;
            end
        end
    end

    property p_bit_period;
        @(posedge clk) disable iff (srst)
        (tick_reg && seen_tick_reg && cfg_stable_reg && !wr_div && !wr_ctrl2) |-> gap_cnt_reg == expect_gap;
    endproperty
    a_bit_period: assert property (p_bit_period) else $error("bit period wrong");

    sequence s_fast_start;
        tick_reg && high_speed && (divisor_reg == 8'h00) && !cfg_wr;
    endsequence
    // config writes inside the period would move the next tick
    sequence s_cfg_quiet;
        (!cfg_wr)[*7] ##1 (!cfg_wr)[*7];
    endsequence
    property p_high_speed_min;
        @(posedge clk) disable iff (srst)
        s_fast_start ##1 s_cfg_quiet |-> ##2 tick_reg;
    endproperty
    a_high_speed_min: assert property (p_high_speed_min) else $error("fast tick not every 16");

    property p_tick_single;
        @(posedge clk) disable iff (srst)
        tick_reg |=> !tick_reg;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick lasted two cycles");

    property p_mode_select;
        @(posedge clk) disable iff (srst)
        wr_ctrl2 |=> high_speed == $past(hs_wdata);
    endproperty
    a_mode_select: assert property (p_mode_select) else $error("speed select not taken");

    property p_divisor_load;
        @(posedge clk) disable iff (srst)
        wr_div |=> divisor_reg == $past(bus_req.wdata);
    endproperty
    a_divisor_load: assert property (p_divisor_load) else $error("divisor not loaded");

    property p_rx_readback;
        @(posedge clk) disable iff (srst)
        (rx_byte_valid ##1 (bus_req.rd && bus_req.addr == `UBG_OFS_DATA && !rx_byte_valid))
            |=> rdata == $past(rx_byte, 2);
    endproperty
    a_rx_readback: assert property (p_rx_readback) else $error("received byte not read back");

    sequence s_write_accepted;
        push_ok && !fifo_out_valid && !tx_valid_reg;
    endsequence
    sequence s_byte_out;
        ##1 tx_byte_valid && tx_byte == $past(bus_req.wdata, 2);
    endsequence
    property p_write_to_tx;
        @(posedge clk) disable iff (srst)
        s_write_accepted |=> s_byte_out;
    endproperty
    a_write_to_tx: assert property (p_write_to_tx) else $error("written byte not sent on");

    property p_shared_tick;
        @(posedge clk) disable iff (srst)
        baud_wrap |=> bit_tick;
    endproperty
    a_shared_tick: assert property (p_shared_tick) else $error("shared tick missing");

    property p_ctrl2_reset;
        @(posedge clk)
        srst |=> ctrl2_reg == `UBG_CTRL2_RESET;
    endproperty
    a_ctrl2_reset: assert property (p_ctrl2_reset) else $error("control two not cleared");

    property p_tick_phase;
        @(posedge clk) disable iff (srst)
        tick_reg |-> (pre_cnt_reg == 7'h00) && (baud_cnt_reg == 8'h00);
    endproperty
    a_tick_phase: assert property (p_tick_phase) else $error("tick out of phase with timer");

    property p_prescale_range;
        @(posedge clk) disable iff (srst)
        pre_cnt_reg < `UBG_PRESCALE_LOW;
    endproperty
    a_prescale_range: assert property (p_prescale_range) else $error("prescaler past its range");

    property p_rdata_idle;
        @(posedge clk) disable iff (srst)
        !bus_req.rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

    property p_rx_capture;
        @(posedge clk) disable iff (srst)
        rx_byte_valid |=> rx_data_reg == $past(rx_byte);
    endproperty
    a_rx_capture: assert property (p_rx_capture) else $error("received byte not captured");

    property p_tx_hold;
        @(posedge clk) disable iff (srst)
        (tx_byte_valid && !tx_byte_ready) |=> tx_byte_valid && $stable(tx_byte);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit byte dropped before taken");

    property p_refused_pulse;
        @(posedge clk) disable iff (srst)
        (wr_data && !fifo_in_ready) |=> wr_refused;
    endproperty
    a_refused_pulse: assert property (p_refused_pulse) else $error("full write not flagged");

    property p_ctrl2_hold;
        @(posedge clk) disable iff (srst)
        !wr_ctrl2 |=> $stable(ctrl2_reg);
    endproperty
    a_ctrl2_hold: assert property (p_ctrl2_hold) else $error("control two changed unasked");
endmodule

module ubg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wp_reg;
    logic [AW-1:0]    rp_reg;
    logic [AW:0]      cnt_reg;
    wire              do_push = in_valid && in_ready;
    wire              do_pop  = out_valid && out_ready;
    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rp_reg];
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_reg[wp_reg] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (do_push) begin
                wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
            end
            if (do_pop) begin
                rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    property p_fifo_bound;
        @(posedge clk) disable iff (srst)
        cnt_reg <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count past depth");
endmodule

// ===== bench/ubg_partner.sv
// far-side serial device model: takes transmit bytes, hands in received ones
`timescale 1ns/1ps
module ubg_partner (
    input  wire logic       clk,
    input  wire logic       stall,
    input  wire logic       send,
    input  wire logic [7:0] send_byte,
    input  wire logic       bit_tick,
    output logic            tx_byte_ready,
    output logic [7:0]      rx_byte,
    output logic            rx_byte_valid
);
    logic [7:0] last_reg = 8'h00;
    // both directions shift on one rate, so a byte is taken only on a tick
    assign tx_byte_ready = !stall && bit_tick;
    always @(posedge clk) begin
        rx_byte_valid <= send;
        if (send) begin
            rx_byte <= send_byte;
            last_reg <= send_byte;
        end else begin
            // no stale copy outside the valid cycle
            rx_byte <= ~last_reg;
        end
    end
endmodule

// ===== bench/tb.sv
// self-checking bench for the baud generator and data buffer block
`timescale 1ns/1ps
`include "ubg_consts.svh"
module tb;
    import ubg_pkg::*;
    logic         clk = 1'b0;
    logic         srst = 1'b1;
    logic         stall = 1'b1;
    logic         send = 1'b0;
    logic         rd_q = 1'b0;
    logic [7:0]   send_byte = 8'h00;
    logic [7:0]   rdata, rx_byte, tx_byte, b;
    logic         rx_byte_valid, tx_byte_valid, tx_byte_ready, bit_tick, wr_refused;
    ubg_bus_req_t bus_req = '0;
    int           miscompares = 0;
    int           n_tests = 0;
    int           nref = 0;
    logic [31:0]  seed = 32'hEBCC4E14;
    logic [7:0]   exp_rd[$];
    logic [7:0]   exp_tx[$];
    logic [7:0]   tn[4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
    logic         th[4] = '{1'b0, 1'b1, 1'b0, 1'b1};

    always #2.5 clk = ~clk;

    ubg_core #(.FIFO_DEPTH(`UBG_FIFO_DEPTH)) ubg_core_i (
        .clk(clk), .srst(srst), .bus_req(bus_req), .rdata(rdata),
        .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid), .tx_byte(tx_byte),
        .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
        .bit_tick(bit_tick), .wr_refused(wr_refused));
    ubg_partner ubg_partner_i (
        .clk(clk), .stall(stall), .send(send), .send_byte(send_byte), .bit_tick(bit_tick),
        .tx_byte_ready(tx_byte_ready), .rx_byte(rx_byte), .rx_byte_valid(rx_byte_valid));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("tests %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // one assignment per edge, so back-to-back strobes never collide
    task automatic req(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req(a, d, 1'b1, 1'b0);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        req(a, 8'h00, 1'b0, 1'b1);
    endtask
    task automatic idle();
        req(4'h0, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic tick_period(input logic [7:0] n, input logic hs);
        int c;
        wr(`UBG_OFS_DIVISOR, n);
        wr(`UBG_OFS_CTRL2, {2'b00, hs, 5'h00});
        idle();
        // first period after a change may be irregular
        repeat (2) @(posedge clk iff bit_tick);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (!bit_tick && c < 20000);
        check(c, (hs ? 16 : 64) * (n + 1));
    endtask

    always @(posedge clk) begin
        rd_q <= bus_req.rd & !srst;
        if (wr_refused === 1'b1)
            nref++;
        if (tx_byte_valid === 1'b1 && tx_byte_ready)
            check(tx_byte, exp_tx.pop_front());
    end
    always @(negedge clk) begin
        if (rd_q)
            check(rdata, exp_rd.pop_front());
        else if (!srst)
            check(rdata, 8'h00);
    end

    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`UBG_OFS_DIVISOR, 8'h00);
        rd(`UBG_OFS_CTRL2, 8'h00);
        rd(`UBG_OFS_DATA, 8'h00);
        rd(4'hF, 8'h00);
        $display("test reset_values done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(`UBG_OFS_DIVISOR, seed[7:0]);
            wr(`UBG_OFS_CTRL2, seed[15:8]);
            rd(`UBG_OFS_DIVISOR, seed[7:0]);
            rd(`UBG_OFS_CTRL2, seed[15:8]);
        end
        wr(4'hF, 8'hA5);
        rd(4'hF, 8'h00);
        $display("test registers done");
        b = seed[23:16];
        send_byte <= b;
        send <= 1'b1;
        idle();
        send <= 1'b0;
        idle();
        rd(`UBG_OFS_DATA, b);
        wr(`UBG_OFS_RXPUSH, ~b);
        rd(`UBG_OFS_DATA, ~b);
        idle();
        $display("test receive done");
        foreach (tn[i])
            tick_period(tn[i], th[i]);
        seed = xs(seed);
        tick_period(seed[7:0], seed[8]);
        $display("test bit_rate done");
        wr(`UBG_OFS_DIVISOR, 8'h00);
        wr(`UBG_OFS_CTRL2, 8'h20);
        for (int i = 0; i < `UBG_FIFO_DEPTH + 2; i++) begin
            seed = xs(seed);
            if (i <= `UBG_FIFO_DEPTH)
                exp_tx.push_back(seed[7:0]);
            wr(`UBG_OFS_DATA, seed[7:0]);
        end
        idle();
        stall <= 1'b0;
        for (int i = 0; i < 2000 && exp_tx.size() > 0; i++)
            @(posedge clk);
        check(32'(exp_tx.size()), 0);
        check(32'(nref), 1);
        $display("test transmit_fifo done");
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`UBG_OFS_CTRL2, 8'h00);
        rd(`UBG_OFS_STATUS, 8'h01);
        idle();
        $display("test mid_reset done");
        end_of_test();
    end
endmodule
